// *** uart_baud_map.vh ***
`ifndef UART_BAUD_MAP_VH
`define UART_BAUD_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_PORT_FUNCTION     16'hFF20
`define ADDR_PORT_ONE_DIR      16'hFF21
`define ADDR_SERIAL_MODE       16'hFF70
`define ADDR_BAUD_GEN_CTRL     16'hFF71

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PORT_FUNCTION      8'h00
`define RST_PORT_ONE_DIR       8'hFF
`define RST_SERIAL_MODE        8'h01
`define RST_BAUD_GEN_CTRL      8'h1F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BGC_SEL_HI             7
`define BGC_SEL_LO             6
`define BGC_FIXED_ZERO         5
`define BGC_DIV_MSB            4
`define BGC_DIV_LSB            0
`define SMC_POWER_BIT          7
`define SMC_TX_EN_BIT          6
`define SMC_RX_EN_BIT          5
`define SMC_FIXED_ONE          0
`define PF_TX_PIN_BIT          3
`define PM_TX_PIN_BIT          3
`define PM_RX_PIN_BIT          2
`define PF_WRITABLE_MASK       8'h08

// ----------------------------------------
// Base clock codes and prescale
// ----------------------------------------
`define SEL_TIMER              2'h0
`define SEL_DIV2               2'h1
`define SEL_DIV8               2'h2
`define SEL_DIV32              2'h3
`define PRESCALE_WIDTH         5

`endif

// *** base_clock_select.v ***
`timescale 1ns/100ps
`include "uart_baud_map.vh"

module base_clock_select (
  input  wire       clk_in,
  input  wire       sys_rst_in,
  input  wire       run_in,
  input  wire [1:0] select_in,
  input  wire       timer_output_in,
  output reg        tick_out
);

  reg [`PRESCALE_WIDTH-1:0] prescale_reg;
  reg                       timer_prev_reg;
  reg                       tick_next;

  // ----------------------------------------
  // Prescaler and edge pick
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      prescale_reg   <= 5'h00;
      timer_prev_reg <= 1'b0;
      tick_out       <= 1'b0;
    end else begin
      prescale_reg   <= prescale_reg + 5'h01;
      timer_prev_reg <= timer_output_in;
      tick_out       <= tick_next;
    end
  end

  // Timer taken internally, no pin needed
  always @* begin
    if (select_in == `SEL_TIMER) begin
      tick_next = timer_output_in & ~timer_prev_reg;
    end else if (select_in == `SEL_DIV2) begin
      tick_next = (prescale_reg[0] == 1'b1);
    end else if (select_in == `SEL_DIV8) begin
      tick_next = (prescale_reg[2:0] == 3'h7);
    end else begin
      tick_next = (prescale_reg == 5'h1F);
    end
  end

endmodule // base_clock_select

// *** baud_divider.v ***
`timescale 1ns/100ps

module baud_divider #(
  parameter WIDTH = 5
) (
  input  wire             clk_in,
  input  wire             sys_rst_in,
  input  wire             run_in,
  input  wire             tick_in,
  input  wire [WIDTH-1:0] divisor_in,
  output reg              counter_clk_out,
  output reg              baud_clk_out,
  output reg              baud_tick_out
);

  reg [WIDTH-1:0] count_reg;

  // ----------------------------------------
  // Divide by k, then halve
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      count_reg       <= {WIDTH{1'b0}};
      counter_clk_out <= 1'b0;
      baud_clk_out    <= 1'b0;
      baud_tick_out   <= 1'b0;
    end else begin
      baud_tick_out <= 1'b0;
      if (tick_in) begin
        if (count_reg >= divisor_in - {{(WIDTH-1){1'b0}}, 1'b1}) begin
          count_reg       <= {WIDTH{1'b0}};
          counter_clk_out <= 1'b1;
          baud_clk_out    <= ~baud_clk_out;
          baud_tick_out   <= 1'b1;
        end else begin
          count_reg       <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
          counter_clk_out <= 1'b0;
        end
      end
    end
  end

endmodule // baud_divider

// *** uart_baud_pin_setup.v ***
`timescale 1ns/100ps
`include "uart_baud_map.vh"

module uart_baud_pin_setup (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [15:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        bit_wr_in,
  input  wire [2:0]  bit_sel_in,
  input  wire        rd_in,
  output reg  [7:0]  rdata_out,
  input  wire        timer_output_in,
  input  wire        serial_tx_data_in,
  input  wire [7:0]  port_latch_in,
  input  wire [7:0]  port_pin_in,
  output reg  [7:0]  port_pin_out,
  output reg  [7:0]  port_pin_oe_out,
  output wire        serial_rx_data_out,
  output wire        baud_clk_out,
  output wire        baud_tick_out,
  output wire        tx_circuit_reset_out,
  output wire        rx_circuit_reset_out,
  output wire        operation_stop_out
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0] port_function_reg;
  reg  [7:0] port_one_direction_reg;
  reg  [7:0] serial_mode_control_reg;
  reg  [7:0] baud_generator_control_reg;
  reg  [7:0] rdata_next;
  reg  [7:0] bit_mask;
  wire       unit_power_on;
  wire       transmit_enable_bit;
  wire       receive_enable_bit;
  wire       base_tick;
  wire [4:0] divisor_select;
  wire       tx_pin_function_bit;
  wire [7:0] bit_onehot;

  assign bit_onehot = 8'h01 << bit_sel_in;

  assign unit_power_on       = serial_mode_control_reg[`SMC_POWER_BIT];
  assign transmit_enable_bit = serial_mode_control_reg[`SMC_TX_EN_BIT];
  assign receive_enable_bit  = serial_mode_control_reg[`SMC_RX_EN_BIT];
  assign divisor_select      = baud_generator_control_reg[`BGC_DIV_MSB:`BGC_DIV_LSB];
  assign tx_pin_function_bit = port_function_reg[`PF_TX_PIN_BIT];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      port_function_reg          <= `RST_PORT_FUNCTION;
      port_one_direction_reg     <= `RST_PORT_ONE_DIR;
      serial_mode_control_reg    <= `RST_SERIAL_MODE;
      baud_generator_control_reg <= `RST_BAUD_GEN_CTRL;
    end else begin
      if (wr_in) begin
        if (addr_in == `ADDR_PORT_FUNCTION) begin
          port_function_reg <= wdata_in & `PF_WRITABLE_MASK;
        end else if (addr_in == `ADDR_PORT_ONE_DIR) begin
          port_one_direction_reg <= wdata_in;
        end else if (addr_in == `ADDR_SERIAL_MODE) begin
          serial_mode_control_reg <= wdata_in | 8'h01;
        end else if (addr_in == `ADDR_BAUD_GEN_CTRL) begin
          baud_generator_control_reg <= {wdata_in[7:6], 1'b0, wdata_in[4:0]};
        end
      end else if (bit_wr_in) begin
        // Bit writes on port and serial mode registers only
        if (addr_in == `ADDR_PORT_FUNCTION) begin
          port_function_reg <= ((port_function_reg & ~bit_onehot) | bit_mask) & `PF_WRITABLE_MASK;
        end else if (addr_in == `ADDR_PORT_ONE_DIR) begin
          port_one_direction_reg <= (port_one_direction_reg & ~bit_onehot) | bit_mask;
        end else if (addr_in == `ADDR_SERIAL_MODE) begin
          serial_mode_control_reg <= (serial_mode_control_reg & ~bit_onehot) | bit_mask | 8'h01;
        end
      end
    end
  end

  always @* begin
    bit_mask = wdata_in[0] ? bit_onehot : 8'h00;
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    if (addr_in == `ADDR_PORT_FUNCTION) begin
      rdata_next = port_function_reg;
    end else if (addr_in == `ADDR_PORT_ONE_DIR) begin
      rdata_next = port_one_direction_reg;
    end else if (addr_in == `ADDR_SERIAL_MODE) begin
      rdata_next = serial_mode_control_reg;
    end else if (addr_in == `ADDR_BAUD_GEN_CTRL) begin
      rdata_next = baud_generator_control_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end
  end

  // ----------------------------------------
  // Baud chain
  // ----------------------------------------
  // Clock held off while unpowered
  base_clock_select u_base (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .run_in          (unit_power_on),
    .select_in       (baud_generator_control_reg[`BGC_SEL_HI:`BGC_SEL_LO]),
    .timer_output_in (timer_output_in),
    .tick_out        (base_tick)
  );

  baud_divider #(
    .WIDTH (5)
  ) u_div (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .run_in          (unit_power_on),
    .tick_in         (base_tick),
    .divisor_in      (divisor_select),
    .counter_clk_out (),
    .baud_clk_out    (baud_clk_out),
    .baud_tick_out   (baud_tick_out)
  );

  assign tx_circuit_reset_out = ~unit_power_on | ~transmit_enable_bit;
  assign rx_circuit_reset_out = ~unit_power_on | ~receive_enable_bit;

  assign operation_stop_out = ~unit_power_on & ~transmit_enable_bit & ~receive_enable_bit;

  assign serial_rx_data_out = unit_power_on ? port_pin_in[`PM_RX_PIN_BIT] : 1'b1;

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_pin
      always @* begin
        port_pin_oe_out[n] = ~port_one_direction_reg[n];
        if (n == `PF_TX_PIN_BIT && tx_pin_function_bit && transmit_enable_bit) begin
          port_pin_out[n] = serial_tx_data_in;
        end else begin
          port_pin_out[n] = port_latch_in[n];
        end
      end
    end
  endgenerate

endmodule // uart_baud_pin_setup

// *** uart_baud_chk.sv ***
`timescale 1ns/100ps
module uart_baud_chk (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire [15:0] addr_in,
  input wire        rd_in,
  input wire [7:0]  rdata_out,
  input wire [7:0]  port_latch_in,
  input wire [7:0]  port_pin_out,
  input wire [7:0]  port_pin_oe_out,
  input wire        serial_rx_data_out,
  input wire        baud_clk_out,
  input wire        baud_tick_out,
  input wire        tx_circuit_reset_out,
  input wire        rx_circuit_reset_out,
  input wire        operation_stop_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // state after reset
  a_reset_state: assert property (disable iff (1'b0) sys_rst_in |=> port_pin_oe_out == 8'h00
    && operation_stop_out && rdata_out == 8'h00) else $error("bad state after reset");
  a_fixed_zero: assert property (rd_in && addr_in == 16'hFF71 |=> !rdata_out[5])
    else $error("fixed bit reads one");
  a_func_mask: assert property (rd_in && addr_in == 16'hFF20 |=> (rdata_out & 8'hF7) == 8'h00)
    else $error("function register stray bit");
  a_stop_resets: assert property (operation_stop_out |-> tx_circuit_reset_out && rx_circuit_reset_out)
    else $error("stop without circuit reset");
  a_rx_forced: assert property (operation_stop_out |-> serial_rx_data_out)
    else $error("receive input not held high");
  a_stop_ports: assert property (operation_stop_out |-> port_pin_out == port_latch_in)
    else $error("pins not ports in stop");
  a_tick_space: assert property (baud_tick_out |=> !baud_tick_out [*8])
    else $error("baud ticks too close");
  a_clk_held: assert property (operation_stop_out && $past(operation_stop_out) |-> !baud_clk_out
    && !baud_tick_out) else $error("baud clock runs while stopped");
endmodule // uart_baud_chk
bind uart_baud_pin_setup uart_baud_chk uart_baud_chk_i (.clk_in, .sys_rst_in, .addr_in, .rd_in, .rdata_out,
  .port_latch_in, .port_pin_out, .port_pin_oe_out, .serial_rx_data_out, .baud_clk_out, .baud_tick_out,
  .tx_circuit_reset_out, .rx_circuit_reset_out, .operation_stop_out);

// *** serial_line_far_end.sv ***
`timescale 1ns/100ps
module serial_line_far_end (
  input  wire drive_in,
  input  wire bit_in,
  output wire rx_line_out
);
  assign rx_line_out = drive_in ? bit_in : 1'b1;
endmodule // serial_line_far_end

// *** tb_uart_baud_pin_setup.sv ***
`timescale 1ns/100ps
module tb_uart_baud_pin_setup;
  reg          clk_in = 1'b0;
  reg          sys_rst_in = 1'b1;
  reg  [15:0]  addr_in = 16'h0000;
  reg  [7:0]   wdata_in = 8'h00;
  reg  [2:0]   bit_sel_in = 3'h0;
  reg          wr_in = 1'b0;
  reg          bit_wr_in = 1'b0;
  reg          rd_in = 1'b0;
  reg          timer_output_in = 1'b0;
  reg  [1:0]   tmr_cnt = 2'h0;
  reg          far_drive = 1'b0;
  reg          far_bit = 1'b0;
  logic [15:0] lfsr = 16'hACC7;
  logic [15:0] exp_q[$];
  logic [5:0]  base_t[4] = '{6'h06, 6'h02, 6'h08, 6'h20};
  wire  [7:0]  rdata_out, port_pin_out, port_pin_oe_out, port_pin_in;
  wire         far_rx, serial_rx_data_out, baud_clk_out, baud_tick_out;
  wire         tx_circuit_reset_out, rx_circuit_reset_out, operation_stop_out;
  wire         serial_tx_in_w;
  int          fails = 0;
  int          checked = 0;
  int          n;
  assign port_pin_in = {lfsr[15:11], far_rx, lfsr[9:8]};
  always #5 clk_in = ~clk_in;
  // ----------------------------------------
  // Stimulus and checking helpers
  // ----------------------------------------
  function automatic logic [15:0] next_lfsr(input logic [15:0] v);
    next_lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Timer rising edge every 6 clocks, so a timer base divides by 6
  // Timer free running, even duty
  always @(negedge clk_in) begin
    lfsr <= next_lfsr(lfsr);
    tmr_cnt <= (tmr_cnt == 2'h2) ? 2'h0 : tmr_cnt + 2'h1;
    if (tmr_cnt == 2'h2) timer_output_in <= ~timer_output_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // Op is {read, bit write, byte write}; for a read d is the expected data
  task automatic bus(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d, input logic [2:0] b);
    @(negedge clk_in);
    addr_in = a;
    wdata_in = d;
    bit_sel_in = b;
    {rd_in, bit_wr_in, wr_in} = op;
    if (op[2]) exp_q.push_back({8'h00, d});
    @(negedge clk_in);
    {rd_in, bit_wr_in, wr_in} = 3'h0;
  endtask
  // Counter restarted by power off, so the first tick is skipped
  task automatic baud(input logic [1:0] sel, input logic [4:0] k);
    logic [15:0] c;
    bus(3'h1, 16'hFF70, 8'h01, 3'h0);
    bus(3'h1, 16'hFF71, {sel, 1'b0, k}, 3'h0);
    bus(3'h1, 16'hFF70, 8'h81, 3'h0);
    for (c = 16'h0000; baud_tick_out !== 1'b1 && c < 16'h0800; c++) @(negedge clk_in);
    @(negedge clk_in);
    for (c = 16'h0001; baud_tick_out !== 1'b1 && c < 16'h0800; c++) @(negedge clk_in);
    chk(c, base_t[sel] * k);
  endtask
  task automatic report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (rd_in === 1'b1) begin
      #1;
      chk(rdata_out, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    fails++;
    report_and_stop;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    bus(3'h4, 16'hFF20, 8'h00, 3'h0);
    bus(3'h4, 16'hFF21, 8'hFF, 3'h0);
    bus(3'h4, 16'hFF71, 8'h1F, 3'h0);
    bus(3'h4, 16'hFF00, 8'h00, 3'h0);
    $display("reset values test done");
    bus(3'h1, 16'hFF71, 8'hFF, 3'h0);
    bus(3'h2, 16'hFF71, 8'h00, 3'h7);
    bus(3'h4, 16'hFF71, 8'hDF, 3'h0);
    bus(3'h1, 16'hFF20, 8'hFF, 3'h0);
    bus(3'h4, 16'hFF20, 8'h08, 3'h0);
    bus(3'h2, 16'hFF20, 8'h00, 3'h3);
    bus(3'h4, 16'hFF20, 8'h00, 3'h0);
    bus(3'h2, 16'hFF21, 8'h00, 3'h3);
    bus(3'h4, 16'hFF21, 8'hF7, 3'h0);
    $display("register access test done");
    baud(2'h3, 5'h1F);
    for (n = 0; n < 8; n++) baud(n[1:0], 5'(8 + lfsr % 24));
    $display("baud divider test done");
    bus(3'h1, 16'hFF20, 8'h08, 3'h0);
    bus(3'h1, 16'hFF70, 8'hE1, 3'h0);
    @(negedge clk_in);
    far_drive = 1'b1;
    repeat (4) begin
      @(posedge clk_in);
      chk(port_pin_out[3], lfsr[5]);
    end
    chk(serial_rx_data_out, 1'b0);
    @(negedge clk_in);
    far_bit = 1'b1;
    @(posedge clk_in);
    chk(serial_rx_data_out, 1'b1);
    @(negedge clk_in);
    far_bit = 1'b0;
    chk(port_pin_oe_out, 8'h08);
    chk({tx_circuit_reset_out, rx_circuit_reset_out, operation_stop_out}, 3'h0);
    bus(3'h1, 16'hFF70, 8'h81, 3'h0);
    chk({tx_circuit_reset_out, rx_circuit_reset_out, operation_stop_out}, 3'h6);
    bus(3'h1, 16'hFF70, 8'h01, 3'h0);
    chk({serial_rx_data_out, operation_stop_out}, 2'h3);
    $display("pin routing test done");
    report_and_stop;
  end
  assign serial_tx_in_w = lfsr[5];
  uart_baud_pin_setup uart_baud_pin_setup_i (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .bit_wr_in,
    .bit_sel_in, .rd_in, .rdata_out, .timer_output_in, .serial_tx_data_in(serial_tx_in_w),
    .port_latch_in(lfsr[7:0]), .port_pin_in, .port_pin_out, .port_pin_oe_out, .serial_rx_data_out,
    .baud_clk_out, .baud_tick_out, .tx_circuit_reset_out, .rx_circuit_reset_out, .operation_stop_out);
  serial_line_far_end serial_line_far_end_i (.drive_in(far_drive), .bit_in(far_bit), .rx_line_out(far_rx));
endmodule // tb_uart_baud_pin_setup
